// ==== crs_partner.sv ====
// Prioritiser and memory model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bench request
	input wire logic raise,
	input wire logic [15:0] vec,
	// Sequencer side
	input wire logic ack,
	input wire crs_pkg::crs_bus_s bus,
	output logic pending,
	output logic [15:0] vector,
	output logic [7:0] rdata
);
	// held until ack
	// Pending stays up until the ack edge, so a late take still sees it
	always_ff @(posedge clk or posedge rst)
		if (rst)
			pending <= 1'b0;
		else if (raise)
			pending <= 1'b1;
		else if (ack)
			pending <= 1'b0;
	// vector of pending
	// Vector is garbage once nothing is pending
	assign vector = pending ? vec : ~vec;
	// Memory bytes follow the address; idle cycles show the inverse
	assign rdata = (bus.valid && !bus.write) ? bus.addr[7:0] ^ 8'h5a :
		~(bus.addr[7:0] ^ 8'h5a);
endmodule : crs_partner
`default_nettype wire

// ==== crs_pkg.sv ====
// Package for the reset, interrupt and wait sequencer
package crs_pkg;
	// Vector addresses for reset entry
	localparam logic [15:0] RESET_VEC_HI = 16'hfffe;
	localparam logic [15:0] RESET_VEC_LO = 16'hffff;
	// Instruction queue depth refilled after a vector fetch
	localparam logic [1:0] QUEUE_FILL = 2'h3;
	// Stack frame size pushed by interrupt entry
	localparam logic [2:0] FRAME_BYTES = 3'h5;
	// Mask bit position inside the condition codes
	localparam int CC_MASK_BIT = 3;
	// Condition code value after reset: mask set
	localparam logic [7:0] CC_RESET = 8'h08;
	// Stack pointer value after reset
	localparam logic [15:0] SP_RESET = 16'h00ff;
	// Cycles of the internal reset source check
	localparam logic [3:0] SRC_CHECK_CYCLES = 4'h4;

	// Sequencer states
	typedef enum logic [4:0] {
		ST_RESET, ST_RV_HI, ST_RV_LO, ST_RV_IDLE, ST_Q0, ST_Q1, ST_Q2,
		ST_RUN, ST_PUSH, ST_SETMASK, ST_VEC_HI, ST_VEC_LO, ST_FREE,
		ST_WAIT, ST_BGND, ST_PULL
	} crs_state_e;

	// Programmer-visible registers; the sequencer saves and restores all but index_high
	typedef struct packed {
		logic [15:0] prog_counter;
		logic [7:0] index_low;
		logic [7:0] index_high;
		logic [7:0] accum;
		logic [7:0] condition_code_register;
	} crs_regs_s;

	// One memory bus cycle issued by the sequencer
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} crs_bus_s;
endpackage : crs_pkg

// ==== crs_reset_gate.sv ====
// Reset source gathering and release timing
`timescale 1ns/1ps
`default_nettype none
module crs_reset_gate (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Reset sources
	input wire logic por,
	input wire logic watchdog_timeout,
	input wire logic ext_reset_n,
	// Result
	output logic reset_active
);
	logic ext_meta;
	logic ext_sync;
	logic por_meta;
	logic por_sync;
	logic [3:0] check_cnt;

	// Pin inputs pass two flops; meta stage feeds only sync stage
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ext_meta <= 1'b1;
			ext_sync <= 1'b1;
			por_meta <= 1'b1;
			por_sync <= 1'b1;
		end
		else
		begin
			ext_meta <= ext_reset_n;
			ext_sync <= ext_meta;
			por_meta <= por;
			por_sync <= por_meta;
		end
	end

	// Source check restarts on any source, ends after fixed count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			check_cnt <= crs_pkg::SRC_CHECK_CYCLES;
		else if (por_sync || watchdog_timeout || !ext_sync)
			check_cnt <= crs_pkg::SRC_CHECK_CYCLES;
		else if (check_cnt != 4'h0)
			check_cnt <= check_cnt - 4'h1;
	end

	assign reset_active = (check_cnt != 4'h0) || !ext_sync;
endmodule : crs_reset_gate
`default_nettype wire

// ==== crs_sequencer.sv ====
// Reset, interrupt and wait entry sequencer for an 8-bit core
// Overview of operation
// - Reset comes from power-on, watchdog timeout or the low reset pin.
// - Any reset aborts current work at once, mid-instruction or not.
// - Reset ends only once the source check is done and the pin is high.
// - Reset exit runs six cycles: vector from fffe and ffff, queue fill.
// - An interrupt is taken only at an instruction boundary.
// - The vector is the highest priority one pending at sequence start.
// - Entry pushes PC low, PC high, index low, accumulator, then CC.
// - After CC is stacked the global mask bit is set.
// - Then the vector high byte is read, then the low byte.
// - One idle bus cycle follows the vector reads.
// - Three program bytes from the vector fill the instruction queue.
// - The index high byte is never stacked.
// - The software trap runs the same sequence, ignoring the mask.
// - Wait clears the mask bit and stops the CPU clocks.
// - In wait, an interrupt or reset restarts clocks, handled as usual.
// - A debug halt in wait enters active background mode; CPU_CLK_EN stays low there.
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Reset sources
	input wire logic POR,
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic EXT_RESET_N,
	// Interrupt prioritiser
	input wire logic IRQ_PENDING,
	input wire logic [15:0] IRQ_VECTOR,
	output logic IRQ_ACK,
	// Execution unit requests
	input wire logic INSN_BOUNDARY,
	input wire logic SOFTWARE_TRAP_INSTRUCTION,
	input wire logic WAIT_INSN,
	input wire logic RETURN_INSN,
	input wire crs_pkg::crs_regs_s CPU_REGS,
	input wire logic [15:0] STACK_PTR_IN,
	// Debug controller
	input wire logic DEBUG_HALT,
	input wire logic BGND_EXIT,
	output logic BGND_ACTIVE,
	// Memory bus
	output crs_pkg::crs_bus_s BUS,
	input wire logic [7:0] BUS_RDATA,
	// Results to the core
	output logic CPU_CLK_EN,
	output logic SEQ_BUSY,
	output logic CORE_ABORT,
	output logic [15:0] NEW_PC,
	output logic [15:0] STACK_PTR,
	output logic [7:0] CC_OUT,
	output logic [23:0] QUEUE_DATA,
	output logic QUEUE_VALID,
	output crs_pkg::crs_regs_s PULLED_REGS,
	output logic PULL_DONE
);
	crs_pkg::crs_state_e state;
	crs_pkg::crs_state_e next_state;
	logic reset_active;
	logic [2:0] step;
	logic [15:0] vec_addr;
	// Vector table address, kept apart from the fetched target
	logic [15:0] vec_src;
	logic [15:0] fetch_ptr;
	logic [15:0] sp;
	logic [7:0] cc;
	logic mask;
	logic irq_take;
	logic [1:0] q_cnt;

	// Reset gathering and release timing
	crs_reset_gate u_reset_gate (
		.clk(SYS_CLK),
		.rst(RST),
		.por(POR),
		.watchdog_timeout(WATCHDOG_TIMEOUT),
		.ext_reset_n(EXT_RESET_N),
		.reset_active(reset_active)
	);

	// Byte pushed at each step of the frame
	function automatic logic [7:0] frame_byte(input logic [2:0] idx,
		input crs_pkg::crs_regs_s r);
		case (idx)
			3'h0: frame_byte = r.prog_counter[7:0];
			3'h1: frame_byte = r.prog_counter[15:8];
			3'h2: frame_byte = r.index_low;
			3'h3: frame_byte = r.accum;
			default: frame_byte = r.condition_code_register;
		endcase
	endfunction : frame_byte

	assign mask = cc[crs_pkg::CC_MASK_BIT];
	assign irq_take = INSN_BOUNDARY &&
		(SOFTWARE_TRAP_INSTRUCTION || (IRQ_PENDING && !mask));

	// Next state selection
	always_comb
	begin
		next_state = state;
		case (state)
			crs_pkg::ST_RESET:
				if (!reset_active)
					next_state = crs_pkg::ST_RV_HI;
			crs_pkg::ST_RV_HI: next_state = crs_pkg::ST_RV_LO;
			crs_pkg::ST_RV_LO: next_state = crs_pkg::ST_RV_IDLE;
			crs_pkg::ST_RV_IDLE: next_state = crs_pkg::ST_Q0;
			crs_pkg::ST_Q0: next_state = crs_pkg::ST_Q1;
			crs_pkg::ST_Q1: next_state = crs_pkg::ST_Q2;
			crs_pkg::ST_Q2: next_state = crs_pkg::ST_RUN;
			crs_pkg::ST_RUN:
			begin
				if (irq_take)
					next_state = crs_pkg::ST_PUSH;
				else if (INSN_BOUNDARY && WAIT_INSN)
					next_state = crs_pkg::ST_WAIT;
				else if (INSN_BOUNDARY && RETURN_INSN)
					next_state = crs_pkg::ST_PULL;
			end
			crs_pkg::ST_PUSH:
				if (step == crs_pkg::FRAME_BYTES - 3'h1)
					next_state = crs_pkg::ST_SETMASK;
			crs_pkg::ST_SETMASK: next_state = crs_pkg::ST_VEC_HI;
			crs_pkg::ST_VEC_HI: next_state = crs_pkg::ST_VEC_LO;
			crs_pkg::ST_VEC_LO: next_state = crs_pkg::ST_FREE;
			crs_pkg::ST_FREE: next_state = crs_pkg::ST_Q0;
			crs_pkg::ST_WAIT:
			begin
				if (IRQ_PENDING)
					next_state = crs_pkg::ST_RUN;
				else if (DEBUG_HALT)
					next_state = crs_pkg::ST_BGND;
			end
			crs_pkg::ST_BGND:
				if (BGND_EXIT)
					next_state = crs_pkg::ST_RUN;
			crs_pkg::ST_PULL:
				if (step == crs_pkg::FRAME_BYTES - 3'h1)
					next_state = crs_pkg::ST_Q0;
			default: next_state = crs_pkg::ST_RESET;
		endcase
	end

	// State register; RST is asynchronous, reset from the gate above is taken on the clock edge
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			state <= crs_pkg::ST_RESET;
		else if (reset_active)
			state <= crs_pkg::ST_RESET;
		else
			state <= next_state;
	end

	// Step counter for push and pull frames
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			step <= 3'h0;
		else if ((state == crs_pkg::ST_PUSH ||
			state == crs_pkg::ST_PULL) &&
			step != crs_pkg::FRAME_BYTES - 3'h1)
			step <= step + 3'h1;
		else
			step <= 3'h0;
	end

	// Vector latch; samples the prioritiser as the sequence starts
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			vec_addr <= 16'h0000;
			vec_src <= 16'h0000;
		end
		else if (state == crs_pkg::ST_RUN && irq_take)
			vec_src <= IRQ_VECTOR;
		else if (state == crs_pkg::ST_VEC_HI ||
			state == crs_pkg::ST_RV_HI)
			vec_addr <= {BUS_RDATA, 8'h00};
		else if (state == crs_pkg::ST_VEC_LO ||
			state == crs_pkg::ST_RV_LO)
			vec_addr <= {vec_addr[15:8], BUS_RDATA};
	end

	// Prioritiser acknowledge only for hardware requests
	assign IRQ_ACK = state == crs_pkg::ST_RUN && irq_take &&
		!SOFTWARE_TRAP_INSTRUCTION;

	// Stack pointer: down on push, up on pull
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			sp <= crs_pkg::SP_RESET;
		else if (state == crs_pkg::ST_RUN && INSN_BOUNDARY)
			sp <= STACK_PTR_IN;
		else if (state == crs_pkg::ST_PUSH)
			sp <= sp - 16'h0001;
		else if (state == crs_pkg::ST_PULL)
			sp <= sp + 16'h0001;
	end

	// Condition codes and the global mask bit
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			cc <= crs_pkg::CC_RESET;
		else if (state == crs_pkg::ST_RESET)
			cc <= crs_pkg::CC_RESET;
		else if (state == crs_pkg::ST_SETMASK)
			cc <= cc | (8'h01 << crs_pkg::CC_MASK_BIT);
		else if (state == crs_pkg::ST_RUN && INSN_BOUNDARY &&
			WAIT_INSN && !irq_take)
			cc <= cc & ~(8'h01 << crs_pkg::CC_MASK_BIT);
		else if (state == crs_pkg::ST_PULL && step == 3'h0)
			cc <= BUS_RDATA;
		else if (state == crs_pkg::ST_RUN && INSN_BOUNDARY)
			cc <= CPU_REGS.condition_code_register;
	end

	// Restored registers; pulls CC, A, X low, PC high, PC low
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			PULLED_REGS <= '0;
		else if (state == crs_pkg::ST_PULL)
		begin
			case (step)
				3'h0: PULLED_REGS.condition_code_register <= BUS_RDATA;
				3'h1: PULLED_REGS.accum <= BUS_RDATA;
				3'h2: PULLED_REGS.index_low <= BUS_RDATA;
				3'h3: PULLED_REGS.prog_counter[15:8] <= BUS_RDATA;
				default: PULLED_REGS.prog_counter[7:0] <= BUS_RDATA;
			endcase
		end
	end

	// Queue fill pointer and collected bytes
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			fetch_ptr <= 16'h0000;
			q_cnt <= 2'h0;
			QUEUE_DATA <= 24'h000000;
		end
		else if (state == crs_pkg::ST_RV_IDLE ||
			state == crs_pkg::ST_FREE)
		begin
			fetch_ptr <= vec_addr;
			q_cnt <= 2'h0;
		end
		else if (state == crs_pkg::ST_PULL &&
			step == crs_pkg::FRAME_BYTES - 3'h1)
		begin
			fetch_ptr <= {PULLED_REGS.prog_counter[15:8], BUS_RDATA};
			q_cnt <= 2'h0;
		end
		else if ((state == crs_pkg::ST_Q0 || state == crs_pkg::ST_Q1 ||
			state == crs_pkg::ST_Q2) &&
			q_cnt != crs_pkg::QUEUE_FILL)
		begin
			fetch_ptr <= fetch_ptr + 16'h0001;
			q_cnt <= q_cnt + 2'h1;
			QUEUE_DATA <= {QUEUE_DATA[15:0], BUS_RDATA};
		end
	end

	// Bus cycle generation for each sequencer state
	always_comb
	begin
		BUS = '0;
		case (state)
			crs_pkg::ST_RV_HI:
				BUS = {1'b1, 1'b0, crs_pkg::RESET_VEC_HI, 8'h00};
			crs_pkg::ST_RV_LO:
				BUS = {1'b1, 1'b0, crs_pkg::RESET_VEC_LO, 8'h00};
			crs_pkg::ST_PUSH:
				BUS = {1'b1, 1'b1, sp, frame_byte(step, CPU_REGS)};
			// Table address held apart: the high byte read must not move it
			crs_pkg::ST_VEC_HI:
				BUS = {1'b1, 1'b0, vec_src, 8'h00};
			crs_pkg::ST_VEC_LO:
				BUS = {1'b1, 1'b0, vec_src | 16'h0001, 8'h00};
			crs_pkg::ST_Q0, crs_pkg::ST_Q1, crs_pkg::ST_Q2:
				BUS = {1'b1, 1'b0, fetch_ptr, 8'h00};
			crs_pkg::ST_PULL:
				BUS = {1'b1, 1'b0, sp + 16'h0001, 8'h00};
			crs_pkg::ST_FREE: BUS = '0;
			default: BUS = '0;
		endcase
	end

	// Status outputs
	// clocks stopped in wait
	assign CPU_CLK_EN = state == crs_pkg::ST_RUN;
	assign SEQ_BUSY = state != crs_pkg::ST_RUN &&
		state != crs_pkg::ST_WAIT && state != crs_pkg::ST_BGND;
	assign CORE_ABORT = state == crs_pkg::ST_RESET;
	assign BGND_ACTIVE = state == crs_pkg::ST_BGND;
	assign QUEUE_VALID = state == crs_pkg::ST_Q2;
	assign PULL_DONE = state == crs_pkg::ST_PULL &&
		step == crs_pkg::FRAME_BYTES - 3'h1;
	assign NEW_PC = fetch_ptr;
	assign STACK_PTR = sp;
	assign CC_OUT = cc;
endmodule : crs_sequencer
`default_nettype wire

// ==== crs_sequencer_assertions.sv ====
// Port assertions for the sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_assertions (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Requests
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic EXT_RESET_N,
	input wire logic IRQ_PENDING,
	input wire logic [15:0] IRQ_VECTOR,
	input wire logic INSN_BOUNDARY,
	input wire logic SOFTWARE_TRAP_INSTRUCTION,
	input wire logic WAIT_INSN,
	input wire crs_pkg::crs_regs_s CPU_REGS,
	input wire logic [15:0] STACK_PTR_IN,
	// Responses
	input wire logic IRQ_ACK,
	input wire crs_pkg::crs_bus_s BUS,
	input wire logic CPU_CLK_EN,
	input wire logic CORE_ABORT,
	input wire logic [7:0] CC_OUT
);
	logic [15:0] vq;
	logic free;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	// Vector kept from the ack edge; the input goes stale after it
	always_ff @(posedge SYS_CLK or posedge RST)
		if (RST)
			vq <= 16'h0000;
		else if (IRQ_ACK)
			vq <= IRQ_VECTOR;
	// Boundary with nothing that outranks wait
	assign free = CPU_CLK_EN && INSN_BOUNDARY && !SOFTWARE_TRAP_INSTRUCTION
		&& !(IRQ_PENDING && !CC_OUT[3]);
	sequence rd(logic [15:0] a);
		BUS.valid && !BUS.write && BUS.addr == a;
	endsequence
	sequence wr(logic [15:0] a, logic [7:0] d);
		BUS.valid && BUS.write && BUS.addr == a && BUS.wdata == d;
	endsequence
	sequence fill;
		!BUS.valid ##1 (BUS.valid && !BUS.write) [*3] ##1 CPU_CLK_EN;
	endsequence
	a_wdt_abort: assert property (
		WATCHDOG_TIMEOUT |-> ##[1:2] CORE_ABORT) else $error("late abort");
	a_pin_abort: assert property (
		!EXT_RESET_N |-> ##[1:4] CORE_ABORT) else $error("pin ignored");
	a_reset_exit: assert property (
		$fell(CORE_ABORT) |-> rd(16'hfffe) ##1 rd(16'hffff) ##1 fill)
		else $error("bad reset exit");
	a_take_ok: assert property (
		IRQ_ACK |-> INSN_BOUNDARY && IRQ_PENDING && !CC_OUT[3])
		else $error("bad take");
	a_push_order: assert property (
		IRQ_ACK |=> wr(STACK_PTR_IN, CPU_REGS.prog_counter[7:0])
		##1 wr(STACK_PTR_IN - 16'h1, CPU_REGS.prog_counter[15:8])
		##1 wr(STACK_PTR_IN - 16'h2, CPU_REGS.index_low)
		##1 wr(STACK_PTR_IN - 16'h3, CPU_REGS.accum))
		else $error("bad push");
	a_vec_fill: assert property (
		IRQ_ACK |-> ##7 rd(vq) ##1 rd(vq | 16'h0001) ##1 fill)
		else $error("bad vector");
	a_mask_set: assert property (
		(IRQ_ACK || (SOFTWARE_TRAP_INSTRUCTION && INSN_BOUNDARY && CPU_CLK_EN))
		|-> ##[6:7] CC_OUT[3]) else $error("mask not set");
	a_wait_stop: assert property (
		free && WAIT_INSN |=> !CPU_CLK_EN ##[0:1] !CC_OUT[3])
		else $error("wait failed");
endmodule : crs_sequencer_assertions
`default_nettype wire

// ==== crs_sequencer_tb.sv ====
// Self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_tb;
	logic clk = 0, rst = 1, por = 0, wdt = 0, pin_n = 1, raise = 0;
	logic dbg = 0, bx = 0, ack, pend, bgnd, clk_en, abort, pdone;
	logic bnd = 1;
	logic [2:0] req = 3'h0;
	logic [15:0] vector, sp, sp_in = 16'h00ff, la [16];
	logic [7:0] rdata, cc, ld [16];
	logic [7:0] pd [4] = '{8'h34, 8'h12, 8'h56, 8'h78};
	crs_pkg::crs_bus_s bus;
	crs_pkg::crs_regs_s regs = 48'h1234_56_9a_78_00, pulled;
	int n = 0, acks = 0, errors = 0, n_compared = 0, cycles = 0, k;
	// Clock
	always #2.5 clk = ~clk;
	crs_partner i_partner (.clk(clk), .rst(rst), .raise(raise),
		.vec(16'h8000), .ack(ack), .bus(bus), .pending(pend),
		.vector(vector), .rdata(rdata));
	crs_sequencer i_dut (.SYS_CLK(clk), .RST(rst), .POR(por),
		.WATCHDOG_TIMEOUT(wdt), .EXT_RESET_N(pin_n), .IRQ_PENDING(pend),
		.IRQ_VECTOR(vector), .IRQ_ACK(ack), .INSN_BOUNDARY(bnd),
		.SOFTWARE_TRAP_INSTRUCTION(req[0]), .WAIT_INSN(req[1]),
		.RETURN_INSN(req[2]), .CPU_REGS(regs), .STACK_PTR_IN(sp_in),
		.DEBUG_HALT(dbg), .BGND_EXIT(bx), .BGND_ACTIVE(bgnd), .BUS(bus),
		.BUS_RDATA(rdata), .CPU_CLK_EN(clk_en), .SEQ_BUSY(),
		.CORE_ABORT(abort), .NEW_PC(), .STACK_PTR(sp), .CC_OUT(cc),
		.QUEUE_DATA(), .QUEUE_VALID(), .PULLED_REGS(pulled),
		.PULL_DONE(pdone));
	// Bus log, ack count and hang guard; sampled mid-cycle when settled
	always @(negedge clk)
	begin
		cycles++;
		if (ack === 1'b1)
			acks++;
		if (bus.valid === 1'b1 && n < 16)
		begin
			la[n] = bus.addr;
			ld[n] = bus.wdata;
			n++;
		end
		if (cycles == 5000)
		begin
			errors++;
			test_done;
		end
	end
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : chk
	task test_done;
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	// One-cycle request at a boundary
	task pulse(input logic [2:0] v);
		@(posedge clk) req <= v;
		@(posedge clk) req <= 3'h0;
	endtask : pulse
	// Bounded wait for m logged cycles and the core running
	task wlog(input int m);
		for (int j = 0; j < 80 && (n < m || clk_en !== 1'b1); j++)
			@(negedge clk);
	endtask : wlog
	task t_reset_exit;
		wlog(5);
		chk(la[0], 16'hfffe);
		chk(la[1], 16'hffff);
		chk(la[2], 16'ha4a5);
		chk(la[4], 16'ha4a7);
		chk(n, 5);
		chk(cc, crs_pkg::CC_RESET);
		chk(sp, crs_pkg::SP_RESET);
	endtask : t_reset_exit
	task t_wait_irq;
		n = 0;
		pulse(3'h2);
		repeat (3) @(negedge clk);
		chk(clk_en, 1'b0);
		chk(cc[3], 1'b0);
		@(posedge clk) bnd <= 1'b0;
		@(posedge clk) raise <= 1'b1;
		@(posedge clk) raise <= 1'b0;
		repeat (4) @(negedge clk);
		chk(acks, 0);
		chk(clk_en, 1'b1);
		@(posedge clk) bnd <= 1'b1;
		wlog(10);
		chk(acks, 1);
		for (k = 0; k < 4; k++)
		begin
			chk(la[k], 16'h00ff - k);
			chk(ld[k], pd[k]);
		end
		chk(la[5], 16'h8000);
		chk(la[6], 16'h8001);
		chk(la[7], 16'h5a5b);
		chk(la[9], 16'h5a5d);
		chk(n, 10);
		chk(cc[3], 1'b1);
	endtask : t_wait_irq
	task t_return;
		n = 0;
		@(posedge clk) sp_in <= 16'h00fa;
		pulse(3'h4);
		wlog(5);
		for (k = 0; k < 5; k++)
			chk(la[k], 16'h00fb + k);
		chk(pulled.prog_counter, 16'ha4a5);
		chk(pulled.condition_code_register, 8'ha1);
		@(posedge clk) sp_in <= 16'h00ff;
	endtask : t_return
	task t_debug;
		pulse(3'h2);
		repeat (3) @(negedge clk);
		@(posedge clk) dbg <= 1'b1;
		for (k = 0; k < 20 && bgnd !== 1'b1; k++)
			@(negedge clk);
		chk(bgnd, 1'b1);
		@(posedge clk) dbg <= 1'b0;
		@(posedge clk) bx <= 1'b1;
		@(posedge clk) bx <= 1'b0;
		wlog(0);
		chk(bgnd, 1'b0);
	endtask : t_debug
	task t_trap_mask;
		n = 0;
		acks = 0;
		pulse(3'h1);
		wlog(10);
		chk(acks, 0);
		chk(ld[1], 8'h12);
		chk(n, 10);
		chk(cc[3], 1'b1);
		// Core now reports the mask it was handed
		@(posedge clk) regs.condition_code_register <= 8'h08;
		n = 0;
		@(posedge clk) raise <= 1'b1;
		@(posedge clk) raise <= 1'b0;
		repeat (10) @(negedge clk);
		chk(acks, 0);
		chk(n, 0);
	endtask : t_trap_mask
	task t_sources;
		for (int s = 0; s < 3; s++)
		begin
			@(posedge clk)
			begin
				por <= (s == 0);
				wdt <= (s == 1);
				pin_n <= (s != 2);
			end
			repeat (10) @(negedge clk);
			chk(abort, 1'b1);
			n = 0;
			@(posedge clk)
			begin
				por <= 1'b0;
				wdt <= 1'b0;
				pin_n <= 1'b1;
			end
			t_reset_exit;
		end
	endtask : t_sources
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset_exit;
		t_wait_irq;
		t_return;
		t_debug;
		t_trap_mask;
		t_sources;
		test_done;
	end
endmodule : crs_sequencer_tb
bind crs_sequencer crs_sequencer_assertions i_chk (.SYS_CLK(SYS_CLK),
	.RST(RST), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
	.EXT_RESET_N(EXT_RESET_N), .IRQ_PENDING(IRQ_PENDING),
	.IRQ_VECTOR(IRQ_VECTOR), .INSN_BOUNDARY(INSN_BOUNDARY),
	.SOFTWARE_TRAP_INSTRUCTION(SOFTWARE_TRAP_INSTRUCTION),
	.WAIT_INSN(WAIT_INSN), .CPU_REGS(CPU_REGS), .STACK_PTR_IN(STACK_PTR_IN),
	.IRQ_ACK(IRQ_ACK), .BUS(BUS), .CPU_CLK_EN(CPU_CLK_EN),
	.CORE_ABORT(CORE_ABORT), .CC_OUT(CC_OUT));
`default_nettype wire
